// file: opcode_operand_field_decode.sv
// operand field decoder with the core's special registers on an apb slave
// assumes the opcode class of each word arrives with it, in the same cycle
//
// How it works
// RULE_01: access bit 0 addresses the fixed access region, bank select ignored.
// RULE_02: access bit 1 takes the bank from bank select, joined to 8-bit address.
// RULE_03: destination bit 0 sends result to accumulator, 1 to the file register.
// RULE_04: bit instructions carry a 3-bit index choosing bit 0 to 7.
// RULE_05: normal file address is 8 bits, 00h to FFh.
// RULE_06: two-word move takes a full 12-bit source address, no banking.
// RULE_07: two-word move takes a full 12-bit destination from its second word.
// RULE_08: literals decode as 8, 12 or 20 bits by format.
// RULE_09: table mode picks no change, post-increment, post-decrement or pre-increment.
// RULE_10: branch field is relative two's complement, or absolute for call and goto.
// RULE_11: fast bit 1 saves or restores shadow registers; 0 leaves them alone.
// RULE_12: table pointer is 21 bits, low byte at FF6h.
// RULE_13: 8-bit table latch at FF5h holds the table transfer byte.
// RULE_14: product high byte at FF4h, low byte at FF3h.
// RULE_15: accumulator reachable as file register FE8h.
// RULE_16: pc low at FF9h; high and upper latches at FFAh, FFBh.
// RULE_17: five status flags kept: carry, digit carry, zero, overflow, negative.
// RULE_18: a lone second word, top four bits ones, executes as no-operation.
// RULE_19: one instruction cycle is four clock periods; one or two cycles each.
// RULE_20: don't-care bits never affect decoding.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module opcode_operand_field_decode
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic insn_valid,
   input wire logic [15:0] insn_word,
   input wire opcode_decode_pkg::insn_format_t insn_format,
   input wire logic skip_taken,
   input wire logic [7:0] alu_result,
   input wire logic alu_result_we,
   input wire logic [4:0] alu_flags,
   input wire logic alu_flags_we,
   input wire logic [7:0] mul_operand,
   input wire logic mul_start,
   input wire logic [7:0] table_read_data,
   output logic insn_cycle_strobe,
   output logic decode_valid,
   output logic [11:0] file_addr,
   output logic [11:0] move_dest_addr,
   output logic result_to_file,
   output logic [2:0] bit_index,
   output logic [19:0] literal,
   output opcode_decode_pkg::literal_width_t literal_width,
   output logic [1:0] table_pointer_update_mode,
   output logic [20:0] table_access_addr,
   output logic [7:0] table_write_data,
   output logic table_write_strobe,
   output logic [20:0] branch_target,
   output logic fast_mode,
   output logic executes_as_nop,
   output logic [1:0] insn_cycles,
   output logic [7:0] working_accumulator,
   output logic [4:0] status_flags,
   output logic [20:0] prog_counter
);
   typedef struct packed
   {
      logic [7:0] acc;
      logic [7:0] prod_low;
      logic [7:0] prod_high;
      logic [7:0] tab_latch;
      logic [20:0] tab_ptr;
      logic [20:0] pc;
      logic [7:0] pc_high_latch;
      logic [7:0] pc_upper_latch;
      logic [3:0] bank;
      logic [4:0] flags;
      logic [7:0] shadow_acc;
      logic [4:0] shadow_flags;
      logic [3:0] shadow_bank;
      logic pend_valid;
      opcode_decode_pkg::insn_format_t pend_format;
      logic [15:0] pend_word;
      logic [31:0] rdata;
      logic err;
      logic dec_valid;
      logic [11:0] eff_addr;
      logic [11:0] dest_addr;
      logic to_file;
      logic [2:0] bit_idx;
      logic [19:0] lit;
      opcode_decode_pkg::literal_width_t lit_w;
      logic [1:0] tbl_mode;
      logic [20:0] tbl_addr;
      logic tbl_wr;
      logic [20:0] target;
      logic fast;
      logic nop;
      logic [1:0] cycles;
   } core_state_t;

   core_state_t state;
   core_state_t next_state;
   logic cycle_en;
   logic [20:0] step_addr;
   logic [20:0] step_pointer;
   logic [11:0] reg_index;
   logic [31:0] read_mux;
   logic mapped;
   logic take;
   logic second_word;
   logic [20:0] pc_next_seq;
   logic [15:0] product;

   instr_phase_divider #(
      .PERIODS(opcode_decode_pkg::CYCLE_OSC_PERIODS)
   ) u_divider (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .cycle_en(cycle_en)
   );

   table_pointer_step #(
      .WIDTH(opcode_decode_pkg::PROG_ADDR_W)
   ) u_table_step (
      .pointer(state.tab_ptr),
      .mode(insn_word[1:0]),
      .access_addr(step_addr),
      .next_pointer(step_pointer)
   );

   // read side of the register map, sampled in the setup cycle
   always_comb
   begin
      reg_index = paddr[13:2];
      mapped = 1'b1;
      read_mux = 32'h00000000;
      unique case (reg_index)
         opcode_decode_pkg::IDX_ACCUMULATOR: read_mux = {24'h000000, state.acc}; // RULE_15
         opcode_decode_pkg::IDX_PRODUCT_LOW: read_mux = {24'h000000, state.prod_low}; // RULE_14
         opcode_decode_pkg::IDX_PRODUCT_HIGH: read_mux = {24'h000000, state.prod_high}; // RULE_14
         opcode_decode_pkg::IDX_TABLE_LATCH: read_mux = {24'h000000, state.tab_latch}; // RULE_13
         opcode_decode_pkg::IDX_TABLE_POINTER: read_mux = {11'h000, state.tab_ptr}; // RULE_12
         opcode_decode_pkg::IDX_PC_LOW: read_mux = {24'h000000, state.pc[7:0]}; // RULE_16
         opcode_decode_pkg::IDX_PC_HIGH_LATCH: read_mux = {24'h000000, state.pc_high_latch};
         opcode_decode_pkg::IDX_PC_UPPER_LATCH: read_mux = {24'h000000, state.pc_upper_latch};
         opcode_decode_pkg::IDX_BANK_SELECT: read_mux = {28'h0000000, state.bank};
         opcode_decode_pkg::IDX_STATUS_FLAGS: read_mux = {27'h0000000, state.flags}; // RULE_17
         opcode_decode_pkg::IDX_DECODE_STATUS: read_mux = {state.nop, state.fast, 5'h00, state.to_file,
                                                          state.bit_idx, state.eff_addr, 9'h000};
         default:
         begin
            mapped = 1'b0;
         end
      endcase
   end

   always_comb
   begin
      next_state = state;
      take = insn_valid && cycle_en;
      second_word = state.pend_valid && (insn_word[15:12] == opcode_decode_pkg::SECOND_WORD_TAG);
      pc_next_seq = state.pc + opcode_decode_pkg::PC_STEP;
      product = state.acc * mul_operand;
      next_state.tbl_wr = 1'b0;
      if (take)
      begin
         next_state.dec_valid = 1'b1;
         next_state.pend_valid = 1'b0;
         next_state.nop = 1'b0;
         next_state.fast = 1'b0;
         next_state.lit_w = opcode_decode_pkg::LIT_NONE;
         next_state.cycles = skip_taken ? 2'd2 : 2'd1; // RULE_19
         next_state.pc = pc_next_seq;
         if (second_word)
         begin
            next_state.cycles = 2'd2; // RULE_19
            unique case (state.pend_format)
               opcode_decode_pkg::FMT_MOVE_FIRST:
               begin
                  next_state.dest_addr = insn_word[11:0]; // RULE_07
               end
               opcode_decode_pkg::FMT_LIT12_FIRST:
               begin
                  next_state.lit = {8'h00, state.pend_word[3:0], insn_word[7:0]}; // RULE_08
                  next_state.lit_w = opcode_decode_pkg::LIT_12;
               end
               default:
               begin
                  // goto and call: absolute word address, no sign
                  next_state.lit = {insn_word[11:0], state.pend_word[7:0]}; // RULE_08
                  next_state.lit_w = opcode_decode_pkg::LIT_20;
                  next_state.target = {insn_word[11:0], state.pend_word[7:0], 1'b0}; // RULE_10
                  next_state.pc = {insn_word[11:0], state.pend_word[7:0], 1'b0};
                  next_state.fast = (state.pend_format == opcode_decode_pkg::FMT_CALL_FIRST)
                                    && state.pend_word[opcode_decode_pkg::POS_CALL_FAST];
               end
            endcase
         end
         else if (insn_word[15:12] == opcode_decode_pkg::SECOND_WORD_TAG)
         begin
            next_state.nop = 1'b1; // RULE_18
         end
         else
         begin
            // only the fields of the given format are read; the rest never steer
            unique case (insn_format) // RULE_20
               opcode_decode_pkg::FMT_BYTE,
               opcode_decode_pkg::FMT_BIT:
               begin
                  if (insn_word[opcode_decode_pkg::POS_ACCESS])
                  begin
                     next_state.eff_addr = {state.bank, insn_word[7:0]}; // RULE_02
                  end
                  else if (insn_word[7:0] >= opcode_decode_pkg::ACCESS_SPLIT)
                  begin
                     next_state.eff_addr = {opcode_decode_pkg::ACCESS_HIGH_BANK, insn_word[7:0]}; // RULE_01
                  end
                  else
                  begin
                     next_state.eff_addr = {opcode_decode_pkg::ACCESS_LOW_BANK, insn_word[7:0]}; // RULE_05
                  end
                  if (insn_format == opcode_decode_pkg::FMT_BIT)
                  begin
                     next_state.bit_idx = insn_word[opcode_decode_pkg::POS_BIT_LSB +: 3]; // RULE_04
                     next_state.to_file = 1'b1;
                  end
                  else
                  begin
                     next_state.to_file = insn_word[opcode_decode_pkg::POS_DEST]; // RULE_03
                  end
               end
               opcode_decode_pkg::FMT_LITERAL8:
               begin
                  next_state.lit = {12'h000, insn_word[7:0]}; // RULE_08
                  next_state.lit_w = opcode_decode_pkg::LIT_8;
                  next_state.to_file = 1'b0;
               end
               opcode_decode_pkg::FMT_MOVE_FIRST,
               opcode_decode_pkg::FMT_LIT12_FIRST,
               opcode_decode_pkg::FMT_LONG_FIRST,
               opcode_decode_pkg::FMT_CALL_FIRST:
               begin
                  next_state.pend_valid = 1'b1;
                  next_state.pend_format = insn_format;
                  next_state.pend_word = insn_word;
                  next_state.cycles = 2'd2;
                  if (insn_format == opcode_decode_pkg::FMT_MOVE_FIRST)
                  begin
                     next_state.eff_addr = insn_word[11:0]; // RULE_06
                  end
                  if ((insn_format == opcode_decode_pkg::FMT_CALL_FIRST)
                      && insn_word[opcode_decode_pkg::POS_CALL_FAST])
                  begin
                     next_state.shadow_acc = state.acc; // RULE_11
                     next_state.shadow_flags = state.flags;
                     next_state.shadow_bank = state.bank;
                  end
               end
               opcode_decode_pkg::FMT_BRANCH_LONG:
               begin
                  next_state.target = pc_next_seq + {{9{insn_word[10]}}, insn_word[10:0], 1'b0}; // RULE_10
                  next_state.pc = next_state.target;
                  next_state.cycles = 2'd2;
               end
               opcode_decode_pkg::FMT_BRANCH_SHORT:
               begin
                  // conditional: only taken when the execution side says so
                  next_state.target = pc_next_seq + {{12{insn_word[7]}}, insn_word[7:0], 1'b0}; // RULE_10
                  if (skip_taken)
                  begin
                     next_state.pc = next_state.target;
                  end
               end
               opcode_decode_pkg::FMT_TABLE_READ,
               opcode_decode_pkg::FMT_TABLE_WRITE:
               begin
                  next_state.tbl_mode = insn_word[1:0]; // RULE_09
                  next_state.tbl_addr = step_addr;
                  next_state.tab_ptr = step_pointer; // RULE_12
                  next_state.cycles = 2'd2;
                  if (insn_format == opcode_decode_pkg::FMT_TABLE_READ)
                  begin
                     next_state.tab_latch = table_read_data; // RULE_13
                  end
                  else
                  begin
                     next_state.tbl_wr = 1'b1; // RULE_13
                  end
               end
               opcode_decode_pkg::FMT_RETURN:
               begin
                  next_state.cycles = 2'd2;
                  next_state.fast = insn_word[opcode_decode_pkg::POS_RETURN_FAST];
                  if (insn_word[opcode_decode_pkg::POS_RETURN_FAST])
                  begin
                     next_state.acc = state.shadow_acc; // RULE_11
                     next_state.flags = state.shadow_flags;
                     next_state.bank = state.shadow_bank;
                  end
               end
               opcode_decode_pkg::FMT_PLAIN:
               begin
                  next_state.lit_w = opcode_decode_pkg::LIT_NONE;
               end
            endcase
         end
      end
      // execution side results; destination follows the decoded bit
      if (alu_result_we)
      begin
         if (!state.to_file || (state.eff_addr == opcode_decode_pkg::IDX_ACCUMULATOR))
         begin
            next_state.acc = alu_result; // RULE_03
         end
      end
      if (alu_flags_we)
      begin
         next_state.flags = alu_flags; // RULE_17
      end
      if (mul_start)
      begin
         next_state.prod_high = product[15:8]; // RULE_14
         next_state.prod_low = product[7:0];
      end
      // apb: data sampled in setup, write at the completing edge
      if (psel && !penable)
      begin
         next_state.rdata = pwrite ? 32'h00000000 : read_mux;
         next_state.err = !mapped || (paddr[1:0] != 2'b00);
      end
      if (psel && penable && !state.err && pwrite)
      begin
         unique case (reg_index)
            opcode_decode_pkg::IDX_ACCUMULATOR: next_state.acc = pwdata[7:0]; // RULE_15
            opcode_decode_pkg::IDX_PRODUCT_LOW: next_state.prod_low = pwdata[7:0];
            opcode_decode_pkg::IDX_PRODUCT_HIGH: next_state.prod_high = pwdata[7:0];
            opcode_decode_pkg::IDX_TABLE_LATCH: next_state.tab_latch = pwdata[7:0];
            opcode_decode_pkg::IDX_TABLE_POINTER: next_state.tab_ptr = pwdata[20:0]; // RULE_12
            opcode_decode_pkg::IDX_PC_LOW:
            begin
               // writing the low byte pulls in both latches at once
               next_state.pc = {state.pc_upper_latch[4:0], state.pc_high_latch, pwdata[7:0]}; // RULE_16
            end
            opcode_decode_pkg::IDX_PC_HIGH_LATCH: next_state.pc_high_latch = pwdata[7:0];
            opcode_decode_pkg::IDX_PC_UPPER_LATCH: next_state.pc_upper_latch = pwdata[7:0];
            opcode_decode_pkg::IDX_BANK_SELECT: next_state.bank = pwdata[3:0];
            opcode_decode_pkg::IDX_STATUS_FLAGS: next_state.flags = pwdata[4:0];
            default:
            begin
               next_state.err = state.err;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   // zero wait states: answer in the first access cycle
   assign pready = psel && penable;
   assign pslverr = psel && penable && state.err;
   assign prdata = state.rdata;
   assign insn_cycle_strobe = cycle_en;
   assign decode_valid = state.dec_valid;
   assign file_addr = state.eff_addr;
   assign move_dest_addr = state.dest_addr;
   assign result_to_file = state.to_file;
   assign bit_index = state.bit_idx;
   assign literal = state.lit;
   assign literal_width = state.lit_w;
   assign table_pointer_update_mode = state.tbl_mode;
   assign table_access_addr = state.tbl_addr;
   assign table_write_data = state.tab_latch;
   assign table_write_strobe = state.tbl_wr;
   assign branch_target = state.target;
   assign fast_mode = state.fast;
   assign executes_as_nop = state.nop;
   assign insn_cycles = state.cycles;
   assign working_accumulator = state.acc;
   assign status_flags = state.flags;
   assign prog_counter = state.pc;
endmodule
`default_nettype wire

// file: opcode_decode_pkg.sv
// constants, field positions and types for the operand field decoder
// assumes one core clock; the opcode class of each word comes from outside
package opcode_decode_pkg;
   localparam int INSN_W = 16;
   localparam int DATA_W = 8;
   localparam int FILE_ADDR_W = 12;
   localparam int PROG_ADDR_W = 21;
   localparam int BANK_W = 4;
   localparam int FLAG_W = 5;
   localparam int APB_ADDR_W = 14;
   localparam int APB_DATA_W = 32;
   // instruction cycle length in core clock periods
   localparam int CYCLE_OSC_PERIODS = 4;
   // register indices; byte address is four times the index
   localparam logic [11:0] IDX_ACCUMULATOR = 12'hFE8;
   localparam logic [11:0] IDX_PRODUCT_LOW = 12'hFF3;
   localparam logic [11:0] IDX_PRODUCT_HIGH = 12'hFF4;
   localparam logic [11:0] IDX_TABLE_LATCH = 12'hFF5;
   localparam logic [11:0] IDX_TABLE_POINTER = 12'hFF6;
   localparam logic [11:0] IDX_PC_LOW = 12'hFF9;
   localparam logic [11:0] IDX_PC_HIGH_LATCH = 12'hFFA;
   localparam logic [11:0] IDX_PC_UPPER_LATCH = 12'hFFB;
   localparam logic [11:0] IDX_BANK_SELECT = 12'hFE0;
   localparam logic [11:0] IDX_STATUS_FLAGS = 12'hFD8;
   localparam logic [11:0] IDX_DECODE_STATUS = 12'hFD0;
   // operand field positions
   localparam int POS_ACCESS = 8;
   localparam int POS_DEST = 9;
   localparam int POS_BIT_LSB = 9;
   localparam int POS_CALL_FAST = 8;
   localparam int POS_RETURN_FAST = 0;
   localparam logic [3:0] SECOND_WORD_TAG = 4'hF;
   // access region split: low part maps to bank 0, high part to the top bank
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   // reset values and program counter step
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [20:0] RESET_PROG = 21'h000000;
   localparam logic [20:0] PC_STEP = 21'h000002;

   typedef enum logic [3:0]
   {
      FMT_BYTE,
      FMT_BIT,
      FMT_LITERAL8,
      FMT_MOVE_FIRST,
      FMT_LIT12_FIRST,
      FMT_LONG_FIRST,
      FMT_CALL_FIRST,
      FMT_BRANCH_LONG,
      FMT_BRANCH_SHORT,
      FMT_TABLE_READ,
      FMT_TABLE_WRITE,
      FMT_RETURN,
      FMT_PLAIN
   } insn_format_t;

   typedef enum logic [1:0]
   {
      TBL_NO_CHANGE,
      TBL_POST_INC,
      TBL_POST_DEC,
      TBL_PRE_INC
   } table_mode_t;

   typedef enum logic [1:0]
   {
      LIT_NONE,
      LIT_8,
      LIT_12,
      LIT_20
   } literal_width_t;
endpackage

// file: instr_phase_divider.sv
// divides the core clock into instruction cycles
// assumes a free running clock and an asynchronous active low reset
`timescale 1ns/1ps
`default_nettype none
module instr_phase_divider
#(
   parameter int PERIODS = opcode_decode_pkg::CYCLE_OSC_PERIODS
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   output logic cycle_en
);
   typedef struct packed
   {
      logic [7:0] count;
      logic en;
   } div_state_t;

   div_state_t state;
   div_state_t next_state;

   always_comb
   begin
      next_state = state;
      next_state.en = 1'b0;
      if (state.count == 8'(PERIODS - 1))
      begin
         next_state.count = 8'h00;
         next_state.en = 1'b1; // RULE_19
      end
      else
      begin
         next_state.count = state.count + 8'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign cycle_en = state.en;
endmodule
`default_nettype wire

// file: table_pointer_step.sv
// pointer arithmetic for table reads and writes
// purely combinational; the caller registers the new pointer
`timescale 1ns/1ps
`default_nettype none
module table_pointer_step
#(
   parameter int WIDTH = opcode_decode_pkg::PROG_ADDR_W
)
(
   input wire logic [WIDTH-1:0] pointer,
   input wire logic [1:0] mode,
   output logic [WIDTH-1:0] access_addr,
   output logic [WIDTH-1:0] next_pointer
);
   logic [WIDTH-1:0] plus_one;
   logic [WIDTH-1:0] minus_one;

   always_comb
   begin
      plus_one = pointer + WIDTH'(1);
      minus_one = pointer - WIDTH'(1);
      access_addr = pointer;
      next_pointer = pointer;
      unique case (opcode_decode_pkg::table_mode_t'(mode)) // RULE_09
         opcode_decode_pkg::TBL_NO_CHANGE:
         begin
            next_pointer = pointer;
         end
         opcode_decode_pkg::TBL_POST_INC:
         begin
            next_pointer = plus_one;
         end
         opcode_decode_pkg::TBL_POST_DEC:
         begin
            next_pointer = minus_one;
         end
         opcode_decode_pkg::TBL_PRE_INC:
         begin
            access_addr = plus_one;
            next_pointer = plus_one;
         end
      endcase
   end
endmodule
`default_nettype wire

// file: opcode_decode_props.sv
// assertions on the decoded outputs of the operand field decoder
// assumes one clock domain; bound into the decoder top module
`timescale 1ns/1ps
`default_nettype none
module opcode_decode_props
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic insn_valid,
   input wire logic [15:0] insn_word,
   input wire opcode_decode_pkg::insn_format_t insn_format,
   input wire logic insn_cycle_strobe,
   input wire logic [11:0] file_addr,
   input wire logic result_to_file,
   input wire logic [2:0] bit_index,
   input wire logic [19:0] literal,
   input wire logic [1:0] table_pointer_update_mode,
   input wire logic fast_mode
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   logic take, t_byte;
   // only strobe edges take a word
   assign take = insn_valid && insn_cycle_strobe;
   assign t_byte = take && insn_format == opcode_decode_pkg::FMT_BYTE;
   property p_gap; $rose(insn_cycle_strobe) |=> !insn_cycle_strobe [*3] ##1 insn_cycle_strobe; endproperty
   a_gap: assert property (p_gap) else $error("strobe spacing wrong");
   property p_fixed;
      t_byte && !insn_word[8] |=> file_addr == {{4{$past(insn_word[7])}}, $past(insn_word[7:0])}; endproperty
   a_fixed: assert property (p_fixed) else $error("access region address wrong");
   property p_banked; t_byte && insn_word[8] |=> file_addr[7:0] == $past(insn_word[7:0]); endproperty
   a_banked: assert property (p_banked) else $error("banked address wrong");
   property p_dest; t_byte |=> result_to_file == $past(insn_word[9]); endproperty
   a_dest: assert property (p_dest) else $error("destination wrong");
   property p_bit;
      take && insn_format == opcode_decode_pkg::FMT_BIT |=> bit_index == $past(insn_word[11:9]); endproperty
   a_bit: assert property (p_bit) else $error("bit index wrong");
   property p_lit8;
      take && insn_format == opcode_decode_pkg::FMT_LITERAL8 |=> literal[7:0] == $past(insn_word[7:0]); endproperty
   a_lit8: assert property (p_lit8) else $error("literal wrong");
   property p_mode; take && insn_format == opcode_decode_pkg::FMT_TABLE_READ
      |=> table_pointer_update_mode == $past(insn_word[1:0]); endproperty
   a_mode: assert property (p_mode) else $error("table mode wrong");
   property p_fast;
      take && insn_format == opcode_decode_pkg::FMT_RETURN |=> fast_mode == $past(insn_word[0]); endproperty
   a_fast: assert property (p_fast) else $error("fast select wrong");
   c_banked: cover property (t_byte && insn_word[8]);
   c_fixed: cover property (t_byte && !insn_word[8]);
   c_fast: cover property (take && insn_format == opcode_decode_pkg::FMT_RETURN && insn_word[0]);
endmodule
bind opcode_operand_field_decode opcode_decode_props props (.*);
`default_nettype wire

// file: opcode_operand_field_decode_tb.sv
// self-checking bench: apb register access and decoded instruction words
// assumes the decoder's own package; skip and alu result inputs held idle
`timescale 1ns/1ps
`default_nettype none
module opcode_operand_field_decode_tb;
   logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, insn_valid = 0, skip_taken = 0, slv;
   logic alu_result_we = 0, alu_flags_we = 0, mul_start = 0, pready, pslverr, insn_cycle_strobe, decode_valid;
   logic result_to_file, table_write_strobe, fast_mode, executes_as_nop;
   logic [13:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [15:0] insn_word = '0;
   opcode_decode_pkg::insn_format_t insn_format = opcode_decode_pkg::FMT_PLAIN;
   logic [7:0] alu_result = '0, mul_operand = '0, table_read_data = 8'h5A, working_accumulator, table_write_data;
   logic [4:0] alu_flags = '0, status_flags;
   logic [11:0] file_addr, move_dest_addr;
   logic [11:0] idx [8] = '{12'hFE8, 12'hFF3, 12'hFF4, 12'hFF5, 12'hFF6, 12'hFF9, 12'hFFA, 12'hFFB};
   logic [2:0] bit_index;
   logic [19:0] literal;
   opcode_decode_pkg::literal_width_t literal_width;
   logic [1:0] table_pointer_update_mode, insn_cycles;
   logic [20:0] table_access_addr, branch_target, prog_counter, p;
   int err_total = 0, comparisons = 0;
   always #50 ref_clk = ~ref_clk;
   opcode_operand_field_decode uut (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] ix, input logic [31:0] wd);
      @(posedge ref_clk);
      psel <= 1;
      pwrite <= wr;
      paddr <= {ix, 2'b00};
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rd = prdata;
      slv = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // valid dropped at the take edge so idle cycles never repeat the word
   task automatic insn(input logic [15:0] w, input int f);
      @(posedge ref_clk);
      insn_word <= w;
      insn_format <= opcode_decode_pkg::insn_format_t'(f);
      insn_valid <= 1;
      @(negedge ref_clk);
      repeat (8) if (insn_cycle_strobe !== 1'b1) @(negedge ref_clk);
      @(posedge ref_clk);
      insn_valid <= 0;
      @(negedge ref_clk);
   endtask
   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      #1000000;
      err_total++;
      finish_test;
   end
   initial
   begin
      repeat (20) @(posedge ref_clk);
      reset_n <= 1;
      for (int i = 0; i < 8; i++)
      begin
         apb(1, idx[i], 32'hFFFF31 + i);
         apb(0, idx[i], 0);
         chk(rd, (32'hFFFF31 + i) & (i == 4 ? 32'h1FFFFF : 32'hFF));
      end
      apb(1, 12'hF00, 32'hFF);
      chk(slv, 1);
      apb(0, 12'hF00, 0);
      chk({rd[30:0], slv}, 1);
      apb(1, 12'hFF9, 32'h56);
      @(negedge ref_clk);
      chk(prog_counter, {5'h18, 8'h37, 8'h56});
      chk(working_accumulator, 8'h31);
      apb(1, 12'hFE8, 32'h12);
      mul_operand <= 8'h34;
      mul_start <= 1;
      alu_flags <= 5'h15;
      alu_flags_we <= 1;
      @(posedge ref_clk);
      mul_start <= 0;
      alu_flags_we <= 0;
      @(negedge ref_clk);
      chk(status_flags, 5'h15);
      apb(0, 12'hFF4, 0);
      chk(rd, 8'h03);
      apb(0, 12'hFF3, 0);
      chk(rd, 8'hA8);
      apb(1, 12'hFE0, 32'h5);
      insn(16'h2685, 0);
      chk({decode_valid, insn_cycles, result_to_file, file_addr}, 16'hBF85);
      insn(16'h2585, 0);
      chk({decode_valid, insn_cycles, result_to_file, file_addr}, 16'hA585);
      insn(16'h8A85, 1);
      chk(bit_index, 5);
      insn(16'h0E7F, 2);
      chk({literal_width, literal}, {2'd1, 20'h7F});
      insn(16'hCABC, 3);
      chk(file_addr, 12'hABC);
      insn(16'hF123, 12);
      chk(move_dest_addr, 12'h123);
      insn(16'hF000, 12);
      chk(executes_as_nop, 1);
      insn(16'h0013, 11);
      chk(fast_mode, 1);
      insn(16'h0012, 11);
      chk(fast_mode, 0);
      apb(1, 12'hFF6, 32'h100);
      p = 21'h100;
      for (int m = 0; m < 4; m++)
      begin
         insn({14'h2, m[1:0]}, 9);
         p = (m == 3) ? p + 1 : p;
         chk({table_pointer_update_mode, table_access_addr}, {m[1:0], p});
         p = (m == 1) ? p + 1 : (m == 2) ? p - 1 : p;
      end
      apb(0, 12'hFF6, 0);
      chk(rd, p);
      apb(0, 12'hFF5, 0);
      chk(rd, 8'h5A);
      insn(16'hD7FF, 7);
      chk(branch_target, 21'h183770);
      finish_test;
   end
endmodule
`default_nettype wire
